/* File: design/rrs_seq.sv */
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "rrs_map.svh"
module rrs_seq import rrs_pkg::*; #(
  parameter int ADDR_W = 10,
  parameter int CAL_PERIOD = 8,
  parameter int N_PORTS = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // AXI4-Lite write channels
  input wire logic awvalid_i,
  input wire logic [ADDR_W-1:0] awaddr_i,
  output logic awready_o,
  input wire logic wvalid_i,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  output logic wready_o,
  output logic bvalid_o,
  output logic [1:0] bresp_o,
  input wire logic bready_i,
  // AXI4-Lite read channels
  input wire logic arvalid_i,
  input wire logic [ADDR_W-1:0] araddr_i,
  output logic arready_o,
  output logic rvalid_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  input wire logic rready_i,
  // Measurement front end
  input wire logic sense_i,
  input wire logic hits_reached_i,
  output logic [N_PORTS-1:0] port_o,
  output logic [N_PORTS-1:0] port_oe_n_o,
  output logic meas_start_o
);

  //////////////////////////////////////////////////////////////////////////
  // Registers and state
  logic [7:0] calibration_control;
  rrs_port_cfg_s rlc_port_and_clock_config;
  logic [7:0] rlc_run_control;
  logic sequence_done_flag;
  logic [15:0] cal1;
  logic [15:0] cal2;
  logic [15:0] res [0:7];
  rrs_seq_e state;
  logic tick;
  logic [2:0] low_cnt;
  logic [2:0] cur_port;
  logic [2:0] last_port;
  logic [1:0] slot;
  logic [7:0] ovh_cnt;
  logic [15:0] raw;
  logic [31:0] quo;
  logic [31:0] dvd;
  logic [16:0] rem;
  logic [5:0] steps;
  logic sense_m;
  logic sense_s;
  logic cal_run;
  logic [15:0] cal_cnt;
  logic aw_got;
  logic w_got;
  logic [7:0] aw_idx;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_en;
  rrs_wr_s wr;
  logic rd_err;
  logic [31:0] rd_data;
  logic [7:0] rd_idx;
  logic run_bit;
  logic drv_level;
  logic stop_level;
  logic [16:0] next_rem;
  logic [15:0] dsr;

  assign run_bit = rlc_run_control[`RRS_RUN_BIT];
  assign dsr = cal2 - cal1;

  //////////////////////////////////////////////////////////////////////////
  // Sequencer clock enable
  rrs_clk_div #(
    .CNT_W(6)
  ) u_div (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .sel_i(rlc_port_and_clock_config.sequencer_clock_divider),
    .tick_o(tick)
  );

  // Comparator sense input synchroniser
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sense_m <= 1'b0;
      sense_s <= 1'b0;
    end else begin
      sense_m <= sense_i;
      sense_s <= sense_m;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write side: address and data in either order
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      awready_o <= 1'b1;
      wready_o <= 1'b1;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_idx <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid_o <= 1'b0;
      bresp_o <= `RRS_RESP_OKAY;
    end else begin
      if (awvalid_i && awready_o) begin
        aw_got <= 1'b1;
        awready_o <= 1'b0;
        aw_idx <= awaddr_i[9:2];
      end
      if (wvalid_i && wready_o) begin
        w_got <= 1'b1;
        wready_o <= 1'b0;
        w_data <= wdata_i;
        w_strb <= wstrb_i;
      end
      if (wr_en) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        bvalid_o <= 1'b1;
        bresp_o <= (aw_idx == `RRS_IDX_CAL_CTRL ||
                    aw_idx == `RRS_IDX_PORT_CFG ||
                    aw_idx == `RRS_IDX_RUN_CTRL) ?
                   `RRS_RESP_OKAY : `RRS_RESP_SLVERR;
      end
      if (bvalid_o && bready_i) begin
        bvalid_o <= 1'b0;
        awready_o <= 1'b1;
        wready_o <= 1'b1;
      end
    end
  end

  // One write takes effect once both halves are held
  assign wr_en = aw_got && w_got && !bvalid_o;
  assign wr = '{idx: aw_idx, data: w_data[7:0], lane: w_strb[0]};

  // Control registers written by software
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rlc_port_and_clock_config <= `RRS_PORT_CFG_RST;
      rlc_run_control <= `RRS_RUN_CTRL_RST;
    end else if (wr_en && wr.lane) begin
      if (wr.idx == `RRS_IDX_PORT_CFG) begin
        rlc_port_and_clock_config <= wr.data;
      end
      if (wr.idx == `RRS_IDX_RUN_CTRL) begin
        rlc_run_control <= wr.data;
      end
    end
  end

  // Calibration control: software write, start bit cleared by hardware
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      calibration_control <= `RRS_CAL_CTRL_RST;
    end else if (wr_en && wr.lane && wr.idx == `RRS_IDX_CAL_CTRL) begin
      calibration_control <= wr.data;
    end else if (cal_run && cal_cnt == 16'(2 * CAL_PERIOD)) begin
      calibration_control[`RRS_CAL_START_BIT] <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read side
  assign rd_idx = araddr_i[9:2];

  // Read data selection
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    if (rd_idx >= `RRS_IDX_RES_FIRST && rd_idx <= `RRS_IDX_RES_LAST) begin
      rd_data[15:0] = res[rd_idx[2:0]];
    end else begin
      unique case (rd_idx)
        `RRS_IDX_CAL_CTRL: rd_data[7:0] = calibration_control;
        `RRS_IDX_PORT_CFG: rd_data[7:0] = rlc_port_and_clock_config;
        `RRS_IDX_RUN_CTRL: rd_data[7:0] = rlc_run_control;
        `RRS_IDX_STATUS: begin
          rd_data[`RRS_ST_DONE_BIT] = sequence_done_flag;
          rd_data[`RRS_ST_BUSY_BIT] = (state != SQ_IDLE) &&
                                      (state != SQ_DONE);
          rd_data[`RRS_ST_CAL_BIT] = cal_run;
        end
        `RRS_IDX_CAL1: rd_data[15:0] = cal1;
        `RRS_IDX_CAL2: rd_data[15:0] = cal2;
        default: rd_err = 1'b1;
      endcase
    end
  end

  // Read handshake, data one cycle after the address is taken
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      arready_o <= 1'b1;
      rvalid_o <= 1'b0;
      rdata_o <= 32'h0000_0000;
      rresp_o <= `RRS_RESP_OKAY;
    end else if (arvalid_i && arready_o) begin
      arready_o <= 1'b0;
      rvalid_o <= 1'b1;
      rdata_o <= rd_data;
      rresp_o <= rd_err ? `RRS_RESP_SLVERR : `RRS_RESP_OKAY;
    end else if (rvalid_o && rready_i) begin
      rvalid_o <= 1'b0;
      arready_o <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Calibration: two hits at one and two calibration periods
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cal_run <= 1'b0;
      cal_cnt <= 16'h0000;
      cal1 <= 16'h0000;
      cal2 <= 16'h0000;
    end else if (!cal_run) begin
      cal_cnt <= 16'h0000;
      if (calibration_control[`RRS_CAL_START_BIT] ||
          (calibration_control[`RRS_CAL_AUTO_BIT] && hits_reached_i)) begin
        cal_run <= 1'b1;
      end
    end else begin
      cal_cnt <= cal_cnt + 1'b1;
      if (cal_cnt == 16'(CAL_PERIOD)) begin
        cal1 <= cal_cnt;
      end
      if (cal_cnt == 16'(2 * CAL_PERIOD)) begin
        cal2 <= cal_cnt;
        cal_run <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Rearm counter: run must stay low six divided ticks
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      low_cnt <= 3'd0;
    end else if (run_bit) begin
      if (state == SQ_PREP) begin
        low_cnt <= 3'd0;
      end
    end else if (tick && low_cnt != `RRS_REARM_TICKS) begin
      low_cnt <= low_cnt + 1'b1;
    end
  end

  // Drive level and stop level by mode
  assign drv_level = rlc_port_and_clock_config.cap_select ||
                     rlc_run_control[`RRS_XSW_BIT];
  assign stop_level = rlc_port_and_clock_config.cap_select;

  // One restoring division step
  assign next_rem = {rem[15:0], dvd[31]};

  // Main sequencer
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state <= SQ_IDLE;
      cur_port <= 3'd0;
      last_port <= 3'd0;
      slot <= 2'd0;
      ovh_cnt <= 8'h00;
      raw <= 16'h0000;
      quo <= 32'h0000_0000;
      dvd <= 32'h0000_0000;
      rem <= 17'h0_0000;
      steps <= 6'd0;
      sequence_done_flag <= 1'b0;
      meas_start_o <= 1'b0;
    end else begin
      meas_start_o <= 1'b0;
      if (!run_bit && state != SQ_IDLE) begin
        state <= SQ_IDLE;
      end else begin
        unique case (state)
          SQ_IDLE: begin
            if (tick && run_bit && low_cnt == `RRS_REARM_TICKS) begin
              state <= SQ_PREP;
              sequence_done_flag <= 1'b0;
            end
          end
          SQ_PREP: begin
            slot <= 2'd0;
            ovh_cnt <= 8'h00;
            if (rlc_port_and_clock_config.port_count_or_index == 3'd0) begin
              state <= SQ_DONE;
            end else if (rlc_port_and_clock_config.single) begin
              cur_port <=
                rlc_port_and_clock_config.port_count_or_index;
              last_port <= rlc_port_and_clock_config.port_count_or_index;
              state <= SQ_SETTLE;
            end else begin
              cur_port <= 3'd1;
              last_port <=
                (rlc_port_and_clock_config.port_count_or_index >
                 `RRS_MAX_PORT) ? `RRS_MAX_PORT :
                rlc_port_and_clock_config.port_count_or_index;
              state <= SQ_SETTLE;
            end
          end
          SQ_SETTLE: begin
            raw <= 16'h0000;
            if (tick) begin
              ovh_cnt <= ovh_cnt + 1'b1;
              if (ovh_cnt == `RRS_PORT_OVH) begin
                state <= SQ_DRIVE;
                meas_start_o <= 1'b1;
              end
            end
          end
          SQ_DRIVE: begin
            raw <= raw + 1'b1;
            if (sense_s == stop_level || raw == 16'hffff) begin
              state <= SQ_CALIB;
              dvd <= {raw, 16'h0000};
              rem <= 17'h0_0000;
              steps <= 6'd0;
            end
          end
          SQ_CALIB: begin
            if (!calibration_control[`RRS_CAL_CALIB_BIT]) begin
              quo <= {16'h0000, raw};
              state <= SQ_STORE;
            end else if (steps == `RRS_DIV_STEPS) begin
              state <= SQ_STORE;
            end else begin
              steps <= steps + 1'b1;
              dvd <= {dvd[30:0], 1'b0};
              if (next_rem >= {1'b0, dsr}) begin
                rem <= next_rem - {1'b0, dsr};
                quo <= {quo[30:0], 1'b1};
              end else begin
                rem <= next_rem;
                quo <= {quo[30:0], 1'b0};
              end
            end
          end
          SQ_STORE: begin
            res[{slot, 1'b0}] <= quo[15:0];
            res[{slot, 1'b1}] <= quo[31:16];
            slot <= slot + 1'b1;
            ovh_cnt <= 8'h00;
            if (cur_port >= last_port) begin
              state <= SQ_DONE;
            end else begin
              cur_port <= cur_port + 1'b1;
              state <= SQ_SETTLE;
            end
          end
          SQ_DONE: begin
            sequence_done_flag <= 1'b1;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Per port drivers, enabled only while the sequencer drives that port (SQ_DRIVE)
  for (genvar g = 0; g < N_PORTS; g++) begin : g_port
    always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
        port_o[g] <= 1'b0;
        port_oe_n_o[g] <= 1'b1;
      end else begin
        port_o[g] <= drv_level;
        port_oe_n_o[g] <= !(state == SQ_DRIVE &&
                            cur_port == 3'(g + 1));
      end
    end
  end

endmodule : rrs_seq

/* File: common/rrs_map.svh */
`ifndef RRS_MAP_SVH
`define RRS_MAP_SVH
// Contract
// - A rising run bit in run control starts a port measurement sequence.
// - Host keeps run high; device stops itself and raises the done flag.
// - Device never clears run; restart needs six divided ticks of zero.
// - External switch bit changes port drive for transistors. The code ignores it while the capacitance bit is set.
// - Port field sits in bits 7 to 5, reset value binary 100.
// - Single bit off measures ports 1 to field; on measures that port. With single off the code caps the field at 4 (RRS_MAX_PORT).
// - Same drive for R and L; capacitance bit selects alternative drive.
// - Sequencer clock divider codes 0 to 6 give 1 to 64; 7 gives 64.
// - Control bit 7 starts calibration; device clears it when done.
// - Calibration measures one and two periods, overwrites its values.
// - Own calibration makes its start and two hits a period apart.
// - Auto calibration bit starts calibration once hit count reached.
// - Calibration values stay readable by the host.
// - Eight results and status readable; a sequential unit fills results.
// - The sequence starts on a zero to one edge of the run bit.
// - Per port: measure, calibrate, compute, store, advance the port.
// - About 250 sequencer cycles per port plus the measuring time; the code settles 201 ticks (RRS_PORT_OVH) per port.
// - With calibration each port gives 32 bits over two 16-bit registers.

// Register indices; byte address is four times the index
`define RRS_IDX_CAL_CTRL 8'h00
`define RRS_IDX_PORT_CFG 8'h05
`define RRS_IDX_RUN_CTRL 8'h06
`define RRS_IDX_STATUS 8'h0b
`define RRS_IDX_CAL1 8'h0c
`define RRS_IDX_CAL2 8'h0d
`define RRS_IDX_RES_FIRST 8'h10
`define RRS_IDX_RES_LAST 8'h17

// Field positions
`define RRS_CAL_START_BIT 7
`define RRS_CAL_CALIB_BIT 6
`define RRS_CAL_AUTO_BIT 3
`define RRS_RUN_BIT 3
`define RRS_XSW_BIT 2
`define RRS_ST_DONE_BIT 0
`define RRS_ST_BUSY_BIT 1
`define RRS_ST_CAL_BIT 2

// Reset values
`define RRS_CAL_CTRL_RST 8'h00
`define RRS_PORT_CFG_RST 8'h80
`define RRS_RUN_CTRL_RST 8'h00

// Counts
`define RRS_REARM_TICKS 3'd6
`define RRS_PORT_OVH 8'hc8
`define RRS_MAX_PORT 3'd4
`define RRS_DIV_MAX_CODE 3'd6
`define RRS_DIV_STEPS 6'd32

// Bus answers
`define RRS_RESP_OKAY 2'b00
`define RRS_RESP_SLVERR 2'b10
`endif

/* File: common/rrs_pkg.sv */
package rrs_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    SQ_IDLE, SQ_PREP, SQ_SETTLE, SQ_DRIVE, SQ_CALIB, SQ_STORE, SQ_DONE
  } rrs_seq_e;

  // Layout of the port and clock configuration register
  typedef struct packed {
    logic [2:0] port_count_or_index;
    logic single;
    logic cap_select;
    logic [2:0] sequencer_clock_divider;
  } rrs_port_cfg_s;

  // One taken bus write
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] data;
    logic lane;
  } rrs_wr_s;

endpackage : rrs_pkg

/* File: design/rrs_clk_div.sv */
`timescale 1ns/10ps
`include "rrs_map.svh"
module rrs_clk_div import rrs_pkg::*; #(
  parameter int CNT_W = 6
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Division code
  input wire logic [2:0] sel_i,
  // One-cycle enable at the divided rate
  output logic tick_o
);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] last;

  // Terminal count from the code, top codes saturate
  always_comb begin
    if (sel_i >= `RRS_DIV_MAX_CODE) begin
      last = '1;
    end else begin
      last = CNT_W'((1 << sel_i) - 1);
    end
  end

  // Free running counter and enable pulse
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt <= '0;
      tick_o <= 1'b0;
    end else if (cnt >= last) begin
      cnt <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      tick_o <= 1'b0;
    end
  end

endmodule : rrs_clk_div

/* File: bench/rrs_seq_assertions.sv */
`timescale 1ns/10ps
`include "rrs_map.svh"
module rrs_seq_assertions import rrs_pkg::*; #(
  parameter int ADDR_W = 10,
  parameter int N_PORTS = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Register bus
  input wire logic awvalid_i,
  input wire logic awready_o,
  input wire logic wvalid_i,
  input wire logic wready_o,
  input wire logic bvalid_o,
  input wire logic arvalid_i,
  input wire logic [ADDR_W-1:0] araddr_i,
  input wire logic arready_o,
  input wire logic rvalid_o,
  input wire logic [31:0] rdata_o,
  input wire logic [1:0] rresp_o,
  input wire logic rready_i,
  // Port pins
  input wire logic [N_PORTS-1:0] port_o,
  input wire logic [N_PORTS-1:0] port_oe_n_o,
  input wire logic meas_start_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////////////////////////////////////////
  // Bus handshakes
  sequence s_wr_taken;
    awvalid_i && awready_o && wvalid_i && wready_o;
  endsequence
  sequence s_rd_taken;
    arvalid_i && arready_o;
  endsequence
  // Port drive active state
  sequence s_driving;
    port_oe_n_o != {N_PORTS{1'b1}};
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_write_answer: assert property (s_wr_taken |-> ##[1:2] bvalid_o)
    else $error("write not answered");
  a_read_answer: assert property (s_rd_taken |=> rvalid_o)
    else $error("read not answered");
  a_unmapped_read: assert property (
    arvalid_i && arready_o && araddr_i[ADDR_W-1:2] == 8'h01
    |=> rresp_o == `RRS_RESP_SLVERR && rdata_o == 32'h0)
    else $error("unmapped read not refused");
  a_read_hold: assert property (
    rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
    else $error("read data dropped");
  a_one_port: assert property ($countones(~port_oe_n_o) <= 1)
    else $error("several ports driven");
  a_start_pulse: assert property (meas_start_o |=> !meas_start_o)
    else $error("start pulse too long");
  a_start_drives: assert property (
    meas_start_o |-> ##[0:2] s_driving)
    else $error("start without port drive");
  a_drive_level: assert property (
    s_driving |-> port_o == {N_PORTS{port_o[0]}})
    else $error("port levels differ");
endmodule : rrs_seq_assertions

/* File: bench/rrs_far_model.sv */
`timescale 1ns/10ps
module rrs_far_model import rrs_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Port pins, switch fitted and response delay
  input wire logic [3:0] port_i,
  input wire logic [3:0] port_oe_n_i,
  input wire logic inv_i,
  input wire logic [7:0] dly_i,
  // Comparator output
  output logic sense_o
);
  logic [7:0] cnt;
  logic lvl;
  logic drv;
  logic tgt;
  // Level the node ends on; a fitted switch turns the drive around
  assign drv = port_oe_n_i != 4'hf;
  assign lvl = drv ? |(port_i & ~port_oe_n_i) : port_i[0];
  assign tgt = lvl ^ inv_i;
  // Cycles since the port began to drive
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !drv) begin
      cnt <= 8'h00;
    end else if (cnt != 8'hff) begin
      cnt <= cnt + 8'h01;
    end
  end
  // Released node rests opposite its end level; crosses after the delay
  assign sense_o = (drv && cnt >= dly_i) ? tgt : ~tgt;
endmodule : rrs_far_model

/* File: bench/rrs_seq_tb.sv */
`timescale 1ns/10ps
`include "rrs_map.svh"
module rrs_seq_tb import rrs_pkg::*; ;
  localparam int CAL_P = 8;
  logic clk_i = 1'b0;
  logic rstn_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i;
  logic hits_reached_i, sense_i, awready_o, wready_o, bvalid_o;
  logic arready_o, rvalid_o, meas_start_o;
  logic [9:0] awaddr_i, araddr_i;
  logic [31:0] wdata_i, rdata_o, rd;
  logic [3:0] wstrb_i, port_o, port_oe_n_o, prev_oe;
  logic [1:0] bresp_o, rresp_o, rs;
  logic [7:0] dly;
  logic xsw;
  logic [4:0] seen[$];
  int n_errors = 0, checks_done = 0, cyc = 0, first_cyc = 0;
  // Reference clock
  always #12.5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////
  rrs_seq #(.CAL_PERIOD(CAL_P)) u_dut (.clk_i(clk_i), .rstn_i(rstn_i),
    .awvalid_i(awvalid_i), .awaddr_i(awaddr_i), .awready_o(awready_o),
    .wvalid_i(wvalid_i), .wdata_i(wdata_i), .wstrb_i(wstrb_i),
    .wready_o(wready_o), .bvalid_o(bvalid_o), .bresp_o(bresp_o),
    .bready_i(bready_i), .arvalid_i(arvalid_i), .araddr_i(araddr_i),
    .arready_o(arready_o), .rvalid_o(rvalid_o), .rdata_o(rdata_o),
    .rresp_o(rresp_o), .rready_i(rready_i), .sense_i(sense_i),
    .hits_reached_i(hits_reached_i), .port_o(port_o),
    .port_oe_n_o(port_oe_n_o), .meas_start_o(meas_start_o));
  rrs_far_model u_net (.clk_i(clk_i), .rstn_i(rstn_i), .port_i(port_o),
    .port_oe_n_i(port_oe_n_o), .inv_i(xsw), .dly_i(dly), .sense_o(sense_i));
  // Pin monitor: each new port drive with its level, and the first drive's cycle
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    prev_oe <= port_oe_n_o;
    if (port_oe_n_o != 4'hf && prev_oe == 4'hf) begin
      if (seen.size() == 0) first_cyc = cyc;
      seen.push_back({port_o[0], ~port_oe_n_o});
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict;
    if (n_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  task automatic tmo;
    n_errors++;
    print_verdict();
  endtask : tmo
  // Bus write; address and data offered together, each dropped when taken
  task automatic bus_wr(input logic [7:0] idx, input logic [7:0] d);
    int n;
    logic a;
    logic w;
    n = 0;
    a = 1'b1;
    w = 1'b1;
    @(posedge clk_i);
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    awaddr_i <= {idx, 2'b00};
    wdata_i <= {24'h0, d};
    while (!bvalid_o) begin
      @(posedge clk_i);
      n++;
      if (n > 50) tmo();
      if (a && awready_o) a = 1'b0;
      if (!a) awvalid_i <= 1'b0;
      if (w && wready_o) w = 1'b0;
      if (!w) wvalid_i <= 1'b0;
    end
    rs = bresp_o;
    bready_i <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] idx);
    int n;
    logic a;
    n = 0;
    a = 1'b1;
    @(posedge clk_i);
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    araddr_i <= {idx, 2'b00};
    while (!rvalid_o) begin
      @(posedge clk_i);
      n++;
      if (n > 50) tmo();
      if (a && arready_o) a = 1'b0;
      if (!a) arvalid_i <= 1'b0;
    end
    rd = rdata_o;
    rs = rresp_o;
    rready_i <= 1'b0;
  endtask : bus_rd
  // One sequence: rearm, start, watch pins only, then read the done flag
  task automatic run_seq(input logic [7:0] cfg, input logic [7:0] ctrl,
      input int n, input logic [19:0] exp, input int div);
    int t0;
    int k;
    bus_wr(`RRS_IDX_RUN_CTRL, 8'h00);
    bus_wr(`RRS_IDX_PORT_CFG, cfg);
    repeat (6 * 64 + 8) @(posedge clk_i);
    seen.delete();
    xsw <= ctrl[`RRS_XSW_BIT];
    bus_wr(`RRS_IDX_RUN_CTRL, ctrl);
    t0 = cyc;
    k = 0;
    while (seen.size() < n || port_oe_n_o != 4'hf) begin
      @(posedge clk_i);
      k++;
      if (k > 40000) tmo();
    end
    k = 0;
    do begin
      bus_rd(`RRS_IDX_STATUS);
      k++;
    end while (rd[`RRS_ST_DONE_BIT] !== 1'b1 && k < 100);
    chk(rd[`RRS_ST_DONE_BIT], 1'b1);
    chk(seen.size(), n);
    for (int i = 0; i < seen.size() && i < n; i++) begin
      chk(seen[i], exp[i*5+:5]);
    end
    if (n > 0) begin
      chk(first_cyc - t0 >= 198 * div &&
        first_cyc - t0 <= 203 * div + 40, 1'b1);
      bus_rd(`RRS_IDX_RES_FIRST + 8'h01);
      chk(rd, 32'h0);
      bus_rd(`RRS_IDX_RES_FIRST);
      chk(rd >= dly && rd <= dly + 8'd8, 1'b1);
    end
  endtask : run_seq
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    bus_rd(`RRS_IDX_CAL_CTRL);
    chk(rd, 32'h0);
    bus_rd(`RRS_IDX_PORT_CFG);
    chk(rd, 32'h80);
    bus_rd(`RRS_IDX_RUN_CTRL);
    chk(rd, 32'h0);
    bus_rd(8'h01);
    chk(rs, `RRS_RESP_SLVERR);
    bus_wr(`RRS_IDX_RES_FIRST, 8'h55);
    chk(rs, `RRS_RESP_SLVERR);
  endtask : t_regs
  task automatic t_cal;
    int k;
    k = 0;
    bus_wr(`RRS_IDX_CAL_CTRL, 8'h80);
    do begin
      bus_rd(`RRS_IDX_CAL_CTRL);
      k++;
    end while (rd[7] !== 1'b0 && k < 20);
    chk(rd[7], 1'b0);
    bus_rd(`RRS_IDX_CAL1);
    chk(rd, CAL_P);
    bus_rd(`RRS_IDX_CAL2);
    chk(rd, 2 * CAL_P);
    bus_wr(`RRS_IDX_CAL_CTRL, 8'h08);
    @(posedge clk_i);
    hits_reached_i <= 1'b1;
    @(posedge clk_i);
    hits_reached_i <= 1'b0;
    bus_rd(`RRS_IDX_STATUS);
    chk(rd[`RRS_ST_CAL_BIT], 1'b1);
    repeat (40) @(posedge clk_i);
    bus_wr(`RRS_IDX_CAL_CTRL, 8'h00);
  endtask : t_cal
  // Four ports from the reset field value, then a level without an edge
  task automatic t_multi;
    dly = 8'd3;
    run_seq(8'h80, 8'h08, 4, {5'h08, 5'h04, 5'h02, 5'h01}, 1);
    bus_wr(`RRS_IDX_RUN_CTRL, 8'h08);
    repeat (400) @(posedge clk_i);
    chk(seen.size(), 4);
  endtask : t_multi
  task automatic t_single_cap;
    dly = 8'd40;
    run_seq(8'h7b, 8'h08, 1, 20'h14, 8);
  endtask : t_single_cap
  task automatic t_ext_div;
    dly = 8'd10;
    run_seq(8'h27, 8'h0c, 1, 20'h11, 64);
  endtask : t_ext_div
  task automatic t_zero;
    run_seq(8'h00, 8'h08, 0, 20'h0, 1);
  endtask : t_zero
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rstn_i = 1'b0;
    {awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = 5'h0;
    hits_reached_i = 1'b0;
    awaddr_i = 10'h0;
    araddr_i = 10'h0;
    wdata_i = 32'h0;
    wstrb_i = 4'h1;
    dly = 8'h03;
    xsw = 1'b0;
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_regs();
    t_cal();
    t_zero();
    t_multi();
    t_single_cap();
    t_ext_div();
    print_verdict();
  end
endmodule : rrs_seq_tb

bind rrs_seq rrs_seq_assertions #(.ADDR_W(ADDR_W), .N_PORTS(N_PORTS)) u_chk (
  .clk_i(clk_i), .rstn_i(rstn_i), .awvalid_i(awvalid_i),
  .awready_o(awready_o), .wvalid_i(wvalid_i), .wready_o(wready_o),
  .bvalid_o(bvalid_o), .arvalid_i(arvalid_i), .araddr_i(araddr_i),
  .arready_o(arready_o), .rvalid_o(rvalid_o), .rdata_o(rdata_o),
  .rresp_o(rresp_o), .rready_i(rready_i), .port_o(port_o),
  .port_oe_n_o(port_oe_n_o), .meas_start_o(meas_start_o));
